/* File: dv/hbg_chk.sv */
/* Port checker of the bridge gate control.
   Assumes one clock and the synchronous reset of the top module. */
`timescale 1ns/100ps
module hbg_chk (
	// clock, reset and inputs
	input wire logic clk,
	input wire logic reset,
	input wire logic phase_in_a,
	input wire logic phase_in_b,
	input wire logic disable_hi_in,
	input wire logic disable_hi_float,
	input wire logic enable_disable_n_in,
	input wire logic enable_float,
	input wire logic undervoltage,
	input wire logic short_circuit_det,
	input wire logic temp_foldback,
	// outputs
	input wire logic bridge_out_a,
	input wire logic bridge_out_a_oe,
	input wire logic bridge_out_b,
	input wire logic bridge_out_b_oe,
	input wire logic foldback_active,
	input wire logic sleep_mode,
	input wire logic fault_status_n_out,
	input wire logic fault_status_n_oe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// ==========================================
	// drive and status relations
	out_follow_a: assert property (
		bridge_out_a_oe && bridge_out_b_oe |-> bridge_out_a == $past(phase_in_a)
		&& bridge_out_b == $past(phase_in_b)) else $error("phase not followed");
	dis_off_a: assert property (
		(disable_hi_in || disable_hi_float) && enable_disable_n_in && !enable_float
		|=> fault_status_n_oe && !bridge_out_a_oe && !bridge_out_b_oe)
		else $error("disable not obeyed");
	sleep_off_a: assert property (
		!enable_disable_n_in || enable_float
		|=> sleep_mode && !bridge_out_a_oe && !bridge_out_b_oe)
		else $error("sleep not obeyed");
	uv_off_a: assert property (
		undervoltage && enable_disable_n_in && !enable_float
		|=> fault_status_n_oe && !bridge_out_a_oe && !bridge_out_b_oe)
		else $error("undervoltage not obeyed");
	short_latch_a: assert property (
		short_circuit_det && bridge_out_a_oe && enable_disable_n_in
		&& !enable_float && !disable_hi_in && !disable_hi_float && !undervoltage
		|-> ##2 (fault_status_n_oe || sleep_mode) && !bridge_out_a_oe)
		else $error("short not latched in time");
	flag_z_a: assert property (
		fault_status_n_oe |-> !bridge_out_a_oe && !bridge_out_b_oe)
		else $error("driving while flagged");
	od_low_a: assert property (!fault_status_n_out)
		else $error("flag pin drives high");
	fold_cause_a: assert property (
		foldback_active |-> $past(temp_foldback) && $past(enable_disable_n_in))
		else $error("foldback without cause");
endmodule : hbg_chk

/* File: dv/hbg_host_model.sv */
/* Host side of the status flag: pull-up on the open-drain line.
   Assumes the flag pin split into level and enable. */
`timescale 1ns/100ps
module hbg_host_model (
	input wire logic fault_status_n_out,
	input wire logic fault_status_n_oe,
	output logic     fault_line
);
	// released line reads high through the pull-up
	assign fault_line = fault_status_n_oe ? fault_status_n_out : 1'h1;
endmodule : hbg_host_model

/* File: dv/tb_top.sv */
/* Scenario bench of the bridge gate control with verdict.
   Assumes design, host model and checker are compiled first. */
`timescale 1ns/100ps
module tb_top;
	logic clk, reset, phase_in_a, phase_in_b, disable_hi_in;
	logic disable_hi_float, enable_disable_n_in, enable_float;
	logic undervoltage, short_circuit_det, current_limit_threshold;
	logic current_limit_det, temp_foldback, thermal_shutdown_point;
	logic temp_below_hyst, bridge_out_a, bridge_out_a_oe, bridge_out_b;
	logic bridge_out_b_oe, foldback_active, sleep_mode;
	logic fault_status_n_out, fault_status_n_oe, fault_line;
	int   mismatches, comparisons, cycles;
	hbridge_gate_control hbridge_gate_control_i (.*);
	hbg_host_model hbg_host_model_i (
		.fault_status_n_out(fault_status_n_out),
		.fault_status_n_oe (fault_status_n_oe),
		.fault_line        (fault_line)
	);
	// ==========================================
	// helpers
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic chk(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %b expected %b", $time, got, exp);
		end
	endtask : chk
	task automatic chk_rng(input int n, input int lo, input int hi);
		comparisons++;
		if (n < lo || n > hi) begin
			mismatches++;
			$display("[FAIL] %0t count %0d not in %0d..%0d", $time, n, lo, hi);
		end
	endtask : chk_rng
	// v: enable, disable, phase a, phase b
	task automatic drive(input logic [3:0] v);
		{enable_disable_n_in, disable_hi_in, phase_in_a, phase_in_b} = v;
		cyc(1);
	endtask : drive
	// v: driving, out a, out b, flag line
	task automatic chk_out(input logic [3:0] v);
		chk(bridge_out_a_oe, v[3]);
		chk(bridge_out_b_oe, v[3]);
		if (v[3]) begin
			chk(bridge_out_a, v[2]);
			chk(bridge_out_b, v[1]);
		end
		chk(fault_line, v[0]);
	endtask : chk_out
	task automatic hit_short;
		short_circuit_det = 1'h1;
		cyc(1);
		short_circuit_det = 1'h0;
		cyc(2);
	endtask : hit_short
	task automatic report_and_stop;
		if (mismatches == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	// ==========================================
	// scenarios
	task automatic t_disable;
		drive(4'hE);
		chk_out(4'h0);
		drive(4'hA);
		disable_hi_float = 1'h1;
		cyc(1);
		chk_out(4'h0);
		disable_hi_float = 1'h0;
		drive(4'h2);
		chk(sleep_mode, 1'h1);
		chk_out(4'h1);
		enable_float = 1'h1;
		drive(4'hA);
		chk(sleep_mode, 1'h1);
		chk_out(4'h1);
		enable_float = 1'h0;
		drive(4'hA);
		chk_out(4'hD);
	endtask : t_disable
	task automatic t_uv;
		drive(4'h9);
		undervoltage = 1'h1;
		cyc(1);
		chk_out(4'h0);
		undervoltage = 1'h0;
		cyc(1);
		chk_out(4'hB);
	endtask : t_uv
	task automatic t_short;
		drive(4'hA);
		hit_short();
		chk_out(4'h0);
		drive(4'h9);
		cyc(4);
		chk_out(4'h0);
		drive(4'hD);
		drive(4'h9);
		cyc(2);
		chk_out(4'hB);
		hit_short();
		drive(4'h1);
		drive(4'h9);
		cyc(2);
		chk_out(4'hB);
		hit_short();
		reset = 1'h1;
		cyc(1);
		reset = 1'h0;
		cyc(2);
		chk_out(4'hB);
	endtask : t_short
	task automatic t_therm;
		drive(4'hA);
		thermal_shutdown_point = 1'h1;
		cyc(3);
		chk_out(4'h0);
		drive(4'h2);
		drive(4'hA);
		cyc(2);
		chk_out(4'h0);
		{thermal_shutdown_point, temp_below_hyst} = 2'h0;
		drive(4'hE);
		drive(4'hA);
		cyc(2);
		chk_out(4'h0);
		drive(4'h2);
		drive(4'hA);
		cyc(2);
		chk_out(4'hD);
		thermal_shutdown_point = 1'h1;
		cyc(3);
		{thermal_shutdown_point, temp_below_hyst} = 2'h1;
		drive(4'hE);
		drive(4'hA);
		cyc(2);
		chk_out(4'hD);
	endtask : t_therm
	task automatic t_limit;
		int n;
		drive(4'hA);
		cyc(4200);
		{current_limit_threshold, current_limit_det} = 2'h3;
		cyc(1);
		{current_limit_threshold, current_limit_det} = 2'h0;
		cyc(2);
		chk_out(4'h1);
		// a second hit mid off time must not stretch it
		for (n = 0; !bridge_out_a_oe && n < 9000; n++) begin
			{current_limit_threshold, current_limit_det} = {2{n == 100}};
			cyc(1);
		end
		chk_rng(n, 5120, 5130);
		{current_limit_threshold, current_limit_det} = 2'h3;
		for (n = 0; bridge_out_a_oe && n < 9000; n++) begin
			cyc(1);
		end
		chk_rng(n, 4120, 4132);
		{current_limit_threshold, current_limit_det} = 2'h0;
		cyc(5200);
		chk_out(4'hD);
	endtask : t_limit
	// ==========================================
	// clock, timeout and main sequence
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			report_and_stop();
		end
	end
	initial begin
		reset = 1'h1;
		{phase_in_a, phase_in_b, disable_hi_in, disable_hi_float} = 4'h0;
		{enable_disable_n_in, enable_float, undervoltage} = 3'h0;
		{short_circuit_det, current_limit_threshold, current_limit_det} = 3'h0;
		{temp_foldback, thermal_shutdown_point, temp_below_hyst} = 3'h1;
		cyc(12);
		reset = 1'h0;
		cyc(1);
		chk(sleep_mode, 1'h1);
		chk_out(4'h1);
		for (int i = 0; i < 4; i++) begin
			drive({2'h2, i[1:0]});
			chk_out({1'h1, i[1:0], 1'h1});
		end
		t_disable();
		t_uv();
		t_short();
		t_therm();
		t_limit();
		temp_foldback = 1'h1;
		cyc(1);
		chk(foldback_active, 1'h1);
		temp_foldback = 1'h0;
		cyc(1);
		chk(foldback_active, 1'h0);
		report_and_stop();
	end
endmodule : tb_top

bind hbridge_gate_control hbg_chk hbg_chk_i (.*);

/* File: rtl/hbg_defs.svh */
/*
 * Constants of the bridge gate control: timing counts at 250 MHz.
 * Assumes one 250 MHz clock; included by the design files by bare name.
 */
`ifndef HBG_DEFS_SVH
`define HBG_DEFS_SVH

// =====================================================================
// clock and times
`define HBG_CLK_MHZ        250
`define HBG_OFF_TIME_NS    20500
`define HBG_BLANK_TIME_NS  16500
`define HBG_FAULT_TIME_NS  8000
`define HBG_OFF_CYC   ((`HBG_OFF_TIME_NS * `HBG_CLK_MHZ) / 1000)
`define HBG_BLANK_CYC ((`HBG_BLANK_TIME_NS * `HBG_CLK_MHZ) / 1000)
`define HBG_FAULT_CYC ((`HBG_FAULT_TIME_NS * `HBG_CLK_MHZ) / 1000)
`define HBG_TMR_W          16

`endif

/* File: rtl/hbg_gate_fault.sv */
/*
 * Fault latch: short-circuit and overtemperature latch-off with the
 * clear edges of the enable and disable inputs.
 * Assumes inputs synchronous to clk; reset models supply restore.
 */
`timescale 1ns/100ps
module hbg_gate_fault (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// detectors
	input  wire logic short_det,
	input  wire logic over_temp,
	input  wire logic temp_below_hyst,
	// clear edges
	input  wire logic dis_fall,
	input  wire logic en_rise,
	// result
	output logic      latched
);
	logic latch_q, latch_d;
	logic clr;

	// =================================================================
	// latch
	always_comb begin
		// enable edge clears only below shutdown, disable edge below
		// shutdown minus hysteresis
		clr = (en_rise & ~over_temp)
			| (dis_fall & temp_below_hyst & ~over_temp);
		latch_d = latch_q;
		if (clr) begin
			latch_d = 1'b0;
		end
		// a new fault wins over a clear in the same cycle
		if (short_det | over_temp) begin
			latch_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			latch_q <= 1'b0;
		end else begin
			latch_q <= latch_d;
		end
	end

	assign latched = latch_q;
endmodule : hbg_gate_fault

/* File: rtl/hbg_pkg.sv */
/*
 * Types shared by the bridge gate control modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package hbg_pkg;
	// output drive of one half bridge
	typedef enum logic [1:0] {
		HBG_DRV_Z,
		HBG_DRV_LO,
		HBG_DRV_HI
	} hbg_drive_type;

	// regulation state of the current limit loop
	typedef enum logic [1:0] {
		HBG_REG_BLANK,
		HBG_REG_ON,
		HBG_REG_OFF
	} hbg_reg_type;
endpackage : hbg_pkg

/* File: rtl/hbg_timers.sv */
/*
 * Blanking and constant-off down counters.
 * Assumes start pulses from the control core, synchronous reset.
 */
`timescale 1ns/100ps
`include "hbg_defs.svh"
module hbg_timers (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// control side
	hbg_tmr_if.tmr    tmr
);
	import hbg_pkg::*;

	localparam logic [`HBG_TMR_W-1:0] BLANK_LD =
		`HBG_TMR_W'(`HBG_BLANK_CYC);
	localparam logic [`HBG_TMR_W-1:0] OFF_LD =
		`HBG_TMR_W'(`HBG_OFF_CYC);

	logic [`HBG_TMR_W-1:0] blank_q, blank_d;
	logic [`HBG_TMR_W-1:0] off_q, off_d;

	// =================================================================
	// counters
	always_comb begin
		blank_d = blank_q;
		off_d   = off_q;
		if (tmr.start_blank) begin
			blank_d = BLANK_LD;
		end else if (blank_q != '0) begin
			blank_d = blank_q - 1'b1;
		end
		if (tmr.start_off) begin
			off_d = OFF_LD;
		end else if (off_q != '0) begin
			off_d = off_q - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			blank_q <= '0;
			off_q   <= '0;
		end else begin
			blank_q <= blank_d;
			off_q   <= off_d;
		end
	end

	assign tmr.blank_busy = (blank_q != '0);
	assign tmr.off_busy   = (off_q != '0);
endmodule : hbg_timers

/* File: rtl/hbg_tmr_if.sv */
/*
 * Interface between the control core and its timer block.
 * Assumes one clock domain.
 */
`timescale 1ns/100ps
interface hbg_tmr_if;
	logic start_blank;
	logic start_off;
	logic blank_busy;
	logic off_busy;

	modport ctrl (
		output start_blank,
		output start_off,
		input  blank_busy,
		input  off_busy
	);
	modport tmr (
		input  start_blank,
		input  start_off,
		output blank_busy,
		output off_busy
	);
endinterface : hbg_tmr_if

/* File: rtl/hbridge_gate_control.sv */
/*
 * Gate control of one H-bridge, both halves A and B: polarity logic, sleep, disable,
 * undervoltage, current regulation and fault latch, status flag.
 * Assumes all inputs synchronous to the 250 MHz clk; analog detectors
 * arrive as digital levels; reset stands for supply removal.
 */
`timescale 1ns/100ps
`include "hbg_defs.svh"
module hbridge_gate_control (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// host control inputs, with pin-float indicators
	input  wire logic phase_in_a,
	input  wire logic phase_in_b,
	input  wire logic disable_hi_in,
	input  wire logic disable_hi_float,
	input  wire logic enable_disable_n_in,
	input  wire logic enable_float,
	// analog detectors
	input  wire logic undervoltage,
	input  wire logic short_circuit_det,
	input  wire logic current_limit_threshold,
	input  wire logic current_limit_det,
	input  wire logic temp_foldback,
	input  wire logic thermal_shutdown_point,
	input  wire logic temp_below_hyst,
	// bridge outputs
	output logic      bridge_out_a,
	output logic      bridge_out_a_oe,
	output logic      bridge_out_b,
	output logic      bridge_out_b_oe,
	output logic      foldback_active,
	output logic      sleep_mode,
	// status flag, open drain
	output logic      fault_status_n_out,
	output logic      fault_status_n_oe
);
	import hbg_pkg::*;

	hbg_tmr_if tif ();

	logic en_eff, dis_eff;
	logic en_prev_q, en_prev_d;
	logic dis_prev_q, dis_prev_d;
	logic latched;
	logic run;
	logic run_q, run_d;
	hbg_reg_type reg_q, reg_d;
	logic pa_q, pa_d, pb_q, pb_d;
	hbg_drive_type drv_a, drv_b;
	logic oa_q, oa_d, ob_q, ob_d;
	logic oea_q, oea_d, oeb_q, oeb_d;
	logic sf_q, sf_d;
	logic fb_q, fb_d;
	logic slp_q, slp_d;
	logic cl_hit;

	// =================================================================
	// input qualification
	always_comb begin
		en_eff  = enable_disable_n_in & ~enable_float;
		dis_eff = disable_hi_in | disable_hi_float;
		en_prev_d  = en_eff;
		dis_prev_d = dis_eff;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			en_prev_q  <= 1'b0;
			dis_prev_q <= 1'b1;
		end else begin
			en_prev_q  <= en_prev_d;
			dis_prev_q <= dis_prev_d;
		end
	end

	// =================================================================
	// fault latch, one cycle from detection, far inside 8.0 us
	hbg_gate_fault u_fault (
		.clk             (clk),
		.reset           (reset),
		.short_det       (short_circuit_det & run),
		.over_temp       (thermal_shutdown_point),
		.temp_below_hyst (temp_below_hyst),
		.dis_fall        (dis_prev_q & ~dis_eff),
		.en_rise         (~en_prev_q & en_eff),
		.latched         (latched)
	);

	hbg_timers u_tmr (
		.clk   (clk),
		.reset (reset),
		.tmr   (tif.tmr)
	);

	// =================================================================
	// bridge enable and current regulation
	always_comb begin
		run = en_eff & ~dis_eff & ~undervoltage & ~latched;
		run_d = run;
		// foldback threshold selected by the analog side; flag only
		cl_hit = current_limit_det & current_limit_threshold;
		pa_d = phase_in_a;
		pb_d = phase_in_b;
		reg_d = reg_q;
		tif.start_blank = 1'b0;
		tif.start_off   = 1'b0;
		// any output edge restarts blanking, leaving tri-state as well,
		// so a limit hit right after enable cannot start the off time
		if (run && (!run_q || pa_d != pa_q || pb_d != pb_q)) begin
			tif.start_blank = 1'b1;
			reg_d = HBG_REG_BLANK;
		end else begin
			unique case (reg_q)
				HBG_REG_BLANK: begin
					// limit ignored while blanking
					if (!tif.blank_busy) begin
						reg_d = HBG_REG_ON;
					end
				end
				HBG_REG_ON: begin
					if (run && cl_hit) begin
						tif.start_off = 1'b1;
						reg_d = HBG_REG_OFF;
					end
				end
				HBG_REG_OFF: begin
					// limit events here are dropped, not queued
					if (!tif.off_busy) begin
						tif.start_blank = 1'b1;
						reg_d = HBG_REG_BLANK;
					end
				end
			endcase
		end
		if (!run) begin
			reg_d = HBG_REG_ON;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			reg_q <= HBG_REG_ON;
			run_q <= 1'b0;
			pa_q  <= 1'b0;
			pb_q  <= 1'b0;
		end else begin
			reg_q <= reg_d;
			run_q <= run_d;
			pa_q  <= pa_d;
			pb_q  <= pb_d;
		end
	end

	// =================================================================
	// output stage
	always_comb begin
		drv_a = phase_in_a ? HBG_DRV_HI : HBG_DRV_LO;
		drv_b = phase_in_b ? HBG_DRV_HI : HBG_DRV_LO;
		// tri-state on sleep, disable, undervoltage, latch, off time
		if (!run || reg_q == HBG_REG_OFF) begin
			drv_a = HBG_DRV_Z;
			drv_b = HBG_DRV_Z;
		end
		oa_d  = (drv_a == HBG_DRV_HI);
		ob_d  = (drv_b == HBG_DRV_HI);
		oea_d = (drv_a != HBG_DRV_Z);
		oeb_d = (drv_b != HBG_DRV_Z);
		// sleep keeps flag released; disable, undervoltage and latch pull it low
		sf_d = ~en_eff
			| ~(dis_eff | undervoltage | latched);
		fb_d  = temp_foldback & en_eff;
		slp_d = ~en_eff;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			oa_q  <= 1'b0;
			ob_q  <= 1'b0;
			oea_q <= 1'b0;
			oeb_q <= 1'b0;
			sf_q  <= 1'b1;
			fb_q  <= 1'b0;
			slp_q <= 1'b1;
		end else begin
			oa_q  <= oa_d;
			ob_q  <= ob_d;
			oea_q <= oea_d;
			oeb_q <= oeb_d;
			sf_q  <= sf_d;
			fb_q  <= fb_d;
			slp_q <= slp_d;
		end
	end

	assign bridge_out_a       = oa_q;
	assign bridge_out_b       = ob_q;
	assign bridge_out_a_oe    = oea_q;
	assign bridge_out_b_oe    = oeb_q;
	assign foldback_active    = fb_q;
	assign sleep_mode         = slp_q;
	// open drain: only ever drives low
	assign fault_status_n_out = 1'b0;
	assign fault_status_n_oe  = ~sf_q;
endmodule : hbridge_gate_control
